// File: bench/ppi_peripheral_model.sv
// peripheral side of port c: strobe and acknowledge lines plus free input pins
// assumes the bench calls its tasks right after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module ppi_peripheral_model
(
  input wire logic pclk,
  output logic [7:0] pc_pins
);
  // handshake lines pc6, pc4 and pc2 idle high, the peripheral always drives them
  logic [7:0] pins_q = 8'hff;
  assign pc_pins = pins_q;
  ////////////////////////////////////////////////////////////////////////////
  // free pins follow the bench; the handshake bits are never left low here
  task automatic set_free(input logic [7:0] v);
    @(posedge pclk);
    pins_q <= v | 8'h54;
  endtask
  // active-low pulse; width sets a prompt or a slow peripheral
  task automatic pulse(input int idx, input int width);
    @(posedge pclk);
    pins_q[idx] <= 1'b0;
    repeat (width) @(posedge pclk);
    pins_q[idx] <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: bench/ppi_port_c_handshake_status_bench.sv
// self-checking bench for the port c handshake and status block
// assumes the package, design files and peripheral model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ppi_port_c_handshake_status_bench;
  localparam logic [7:0] ctl = ppi_pkg::OFF_CTRL;
  localparam logic [7:0] pta = ppi_pkg::OFF_PORT_A;
  localparam logic [7:0] ptc = ppi_pkg::OFF_PORT_C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ppi_reset, er;
  logic [7:0] paddr, pa_in, pb_in, pc_in, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, v;
  logic [31:0] pwdata, prdata, rd;
  int fails, n_tests, cyc, seed, e, i;
  ppi_port_c_handshake_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ppi_reset(ppi_reset), .pa_in(pa_in),
    .pb_in(pb_in), .pc_in(pc_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe));
  ppi_peripheral_model per_u (.pclk(pclk), .pc_pins(pc_in));
  ////////////////////////////////////////////////////////////////////////////
  // 200 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard, well above the expected run length
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; waits for pready, no latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no latency assumed; only the hang guard ends this wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    wt(2);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h6422;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    ppi_reset = 1'b1;
    pa_in <= 8'($random(seed));
    pb_in <= 8'($random(seed));
    wt(4);
    chk("oe_rst", {8'h0, pa_oe, pb_oe, pc_oe}, 32'h0);
    presetn <= 1'b1;
    wt(10000);
    ppi_reset <= 1'b0;
    wt(4);
    chk("oe_por", {8'h0, pa_oe, pb_oe, pc_oe}, 32'h0);
    v = 8'($random(seed));
    per_u.set_free(v);
    apb(1'b0, ptc, 8'h0);
    chk("pc_read", rd, 32'(v | 8'h54));
    apb(1'b0, ppi_pkg::OFF_PORT_B, 8'h0);
    chk("pb_read", rd, 32'(pb_in));
    chk("pb_read_err", 32'(er), 32'h0);
    apb(1'b0, pta, 8'h0);
    chk("pa_read", rd, 32'(pa_in));
    apb(1'b0, 8'h10, 8'h0);
    chk("slverr", 32'(er), 32'h1);
    chk("unmapped", rd, 32'h0);
    done("inputs");
    // all ports mode 0 output, then every set/reset bit
    apb(1'b1, ctl, 8'h80);
    chk("oe_out", {8'h0, pa_oe, pb_oe, pc_oe}, 32'h00ffffff);
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, ctl, 8'((i << 1) | 1));
      chk("bsr", 32'(pc_out), 32'((2 << i) - 1));
    end
    v = 8'($random(seed));
    apb(1'b1, pta, v);
    apb(1'b1, ppi_pkg::OFF_PORT_B, ~v);
    chk("pa_out", 32'(pa_out), 32'(v));
    chk("pb_out", 32'(pb_out), 32'(8'(~v)));
    apb(1'b1, ctl, 8'h80);
    chk("latch_clr", {8'h0, pa_out, pb_out, pc_out}, 32'h0);
    ppi_reset <= 1'b1;
    wt(20);
    ppi_reset <= 1'b0;
    wt(4);
    chk("short_rst", {8'h0, pa_oe, pb_oe, pc_oe}, 32'h00ffffff);
    ppi_reset <= 1'b1;
    wt(110);
    ppi_reset <= 1'b0;
    wt(4);
    chk("long_rst", {8'h0, pa_oe, pb_oe, pc_oe}, 32'h0);
    done("mode0");
    // group a mode 1 input, free bits output
    apb(1'b1, ctl, 8'hb0);
    chk("oe_a_in", {8'h0, pa_oe, pb_oe, pc_oe}, 32'h0000ffef);
    v = 8'($random(seed));
    apb(1'b1, ptc, v);
    chk("pc_wr", 32'(pc_out & 8'hef), 32'(v & 8'h07));
    apb(1'b1, ctl, 8'h0f);
    chk("pc7_bsr", 32'(pc_out[7]), 32'h1);
    for (e = 0; e < 2; e++)
    begin
      apb(1'b1, ctl, 8'(8 | e));
      // status read while the strobe is still low: full but no irq yet
      fork
        per_u.pulse(4, 8);
        begin
          wt(5);
          apb(1'b0, ptc, 8'h0);
          chk("stb_low", rd & 32'h38, 32'(8'h20 | e << 4));
        end
      join
      wt(3);
      apb(1'b0, ptc, 8'h0);
      chk("stb_done", rd & 32'h38, 32'(8'h20 | e << 4 | e << 3));
      chk("ibf_pin", 32'(pc_out & 8'h28), 32'(8'h20 | e << 3));
      apb(1'b0, pta, 8'h0);
      apb(1'b0, ptc, 8'h0);
      chk("host_rd", rd & 32'h38, 32'(e << 4));
    end
    done("a_input");
    // both groups mode 1 output
    apb(1'b1, ctl, 8'ha4);
    for (e = 0; e < 2; e++)
    begin
      apb(1'b1, ctl, 8'(8'h0c | e));
      apb(1'b1, ctl, 8'(8'h04 | e));
      v = 8'($random(seed));
      apb(1'b1, pta, v);
      apb(1'b1, ppi_pkg::OFF_PORT_B, v);
      chk("pa_out", 32'(pa_out), 32'(v));
      chk("obf_pin", 32'(pc_out & 8'h82), 32'h0);
      apb(1'b0, ptc, 8'h0);
      chk("obf_set", rd & 32'hcf, 32'(e << 6 | e << 2));
      per_u.pulse(6, 2);
      per_u.pulse(2, 5);
      wt(3);
      apb(1'b0, ptc, 8'h0);
      chk("ack", rd & 32'hcf, 32'(8'h82 | e << 6 | e << 3 | e << 2 | e));
      apb(1'b1, pta, v);
      apb(1'b0, ptc, 8'h0);
      chk("host_wr", rd & 32'hcf, 32'(8'h02 | e << 6 | e << 2 | e));
    end
    done("outputs");
    // group a mode 2 beside group b mode 1 input
    apb(1'b1, ctl, 8'hc6);
    apb(1'b1, ctl, 8'h0d);
    apb(1'b1, ctl, 8'h09);
    apb(1'b1, ctl, 8'h05);
    chk("oe_mode2", 32'(pc_oe), 32'h000000ab);
    apb(1'b0, ptc, 8'h0);
    chk("m2_idle", rd & 32'hf8, 32'hd0);
    chk("m2_b_idle", rd & 32'h07, 32'h04);
    per_u.pulse(4, 2);
    wt(3);
    apb(1'b0, ptc, 8'h0);
    chk("m2_stb", rd & 32'hf8, 32'hf8);
    apb(1'b0, pta, 8'h0);
    apb(1'b1, pta, 8'h5a);
    apb(1'b0, ptc, 8'h0);
    chk("m2_wr", rd & 32'hf8, 32'h50);
    per_u.pulse(6, 2);
    wt(3);
    apb(1'b0, ptc, 8'h0);
    chk("m2_ack", rd & 32'hf8, 32'hd8);
    // group b input strobe, then a port b read empties it
    per_u.pulse(2, 2);
    wt(3);
    apb(1'b0, ptc, 8'h0);
    chk("b_stb", rd & 32'h07, 32'h07);
    chk("ibf_b_pin", 32'(pc_out & 8'h03), 32'h03);
    apb(1'b0, ppi_pkg::OFF_PORT_B, 8'h0);
    chk("pb_m1_read", rd, 32'(pb_in));
    apb(1'b0, ptc, 8'h0);
    chk("b_host_rd", rd & 32'h07, 32'h04);
    done("mode2");
    close_out;
  end
endmodule
`default_nettype wire

// File: rtl/ppi_handshake.sv
// one handshake group: buffer-full flags, interrupt enables, interrupt request
// assumes strobe and acknowledge are synchronous to pclk, active low
`timescale 1ns/1ps
`default_nettype none
module ppi_handshake
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strobe_in_n,
  input wire logic ack_in_n,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic is_input,
  input wire logic is_output,
  input wire logic in_ie_set,
  input wire logic in_ie_clr,
  input wire logic out_ie_set,
  input wire logic out_ie_clr,
  input wire logic clr_all,
  output logic input_buffer_full,
  output logic output_buffer_full_n,
  output logic interrupt_request,
  output logic input_irq_enable,
  output logic output_irq_enable
);
  ppi_pkg::hs_state_t s_q;
  ppi_pkg::hs_state_t s_d;
  logic stb_fall;
  logic stb_rise;
  logic ack_fall;
  logic ack_rise;

  assign stb_fall = s_q.stb_q & ~strobe_in_n;
  assign stb_rise = ~s_q.stb_q & strobe_in_n;
  assign ack_fall = s_q.ack_q & ~ack_in_n;
  assign ack_rise = ~s_q.ack_q & ack_in_n;

  // flag updates; a strobe or ack edge wins over a same-cycle host clear, except that in mode 2 a host write clears a strobe-rise request
  always_comb
  begin
    s_d = s_q;
    s_d.stb_q = strobe_in_n;
    s_d.ack_q = ack_in_n;
    if (in_ie_set)
      s_d.in_ie = 1'b1;
    if (in_ie_clr)
      s_d.in_ie = 1'b0;
    if (out_ie_set)
      s_d.out_ie = 1'b1;
    if (out_ie_clr)
      s_d.out_ie = 1'b0;
    if (is_input && host_rd)
    begin
      s_d.in_full = 1'b0;
      s_d.irq = 1'b0;
    end
    if (is_input && stb_fall)
      s_d.in_full = 1'b1;
    if (is_input && stb_rise && s_q.in_full && s_d.in_ie)
      s_d.irq = 1'b1;
    if (is_output && host_wr)
    begin
      s_d.out_full = 1'b1;
      s_d.irq = 1'b0;
    end
    if (is_output && ack_fall)
      s_d.out_full = 1'b0;
    if (is_output && ack_rise && s_d.out_ie)
      s_d.irq = 1'b1;
    if (clr_all)
    begin
      s_d.in_full = 1'b0;
      s_d.out_full = 1'b0;
      s_d.irq = 1'b0;
      s_d.in_ie = 1'b0;
      s_d.out_ie = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{stb_q: 1'b1, ack_q: 1'b1, default: 1'b0};
    else
      s_q <= s_d;
  end

  assign input_buffer_full = s_q.in_full;
  assign output_buffer_full_n = ~s_q.out_full;
  assign interrupt_request = s_q.irq;
  assign input_irq_enable = s_q.in_ie;
  assign output_irq_enable = s_q.out_ie;

  // a strobe fall while in input mode raises the flag next cycle
  a_ibf_on_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (is_input && stb_fall && !clr_all) |=> input_buffer_full)
    else $error("input flag missed strobe");
  // host write without ack fall drops output_buffer_full_n
  a_obf_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    (is_output && host_wr && !ack_fall && !clr_all) |=> !output_buffer_full_n)
    else $error("output flag missed write");
  // in input-only use, a host read clears the request unless a strobe rise coincides
  a_irq_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (is_input && !is_output && host_rd && !stb_rise) |=> !interrupt_request)
    else $error("irq not cleared by read");
  // ack rise with enable raises the request
  a_irq_ack_set: assert property (@(posedge pclk) disable iff (!presetn)
    (is_output && ack_rise && output_irq_enable && !out_ie_clr && !clr_all)
    |=> interrupt_request)
    else $error("irq not raised by ack");
endmodule
`default_nettype wire

// File: rtl/ppi_pkg.sv
// shared constants and carrier types for the port c handshake and status block
// assumes an apb master on pclk, 32-bit data, one aligned word per register
package ppi_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_PORT_A = 8'h00;
  localparam logic [7:0] OFF_PORT_B = 8'h04;
  localparam logic [7:0] OFF_PORT_C = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;

  // control word fields, mode-set form (bit 7 = 1)
  localparam int CW_FLAG = 7;
  localparam int CW_A_MODE_HI = 6;
  localparam int CW_A_MODE_LO = 5;
  localparam int CW_A_DIR = 4;
  localparam int CW_CU_DIR = 3;
  localparam int CW_B_MODE = 2;
  localparam int CW_B_DIR = 1;
  localparam int CW_CL_DIR = 0;
  // bit set/reset form (bit 7 = 0): bits 3..1 select, bit 0 value
  localparam int BSR_SEL_HI = 3;
  localparam int BSR_SEL_LO = 1;
  localparam int BSR_VAL = 0;

  // reset values: all ports input, mode 0
  localparam logic [7:0] CTRL_RESET = 8'h9b;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // minimum reset pulse that forces input mode
  localparam int RESET_MIN_NS = 500;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // one handshake group
  typedef struct packed {
    logic in_full;
    logic out_full;
    logic irq;
    logic in_ie;
    logic out_ie;
    logic stb_q;
    logic ack_q;
  } hs_state_t;

endpackage

// File: rtl/ppi_port_c_handshake_status.sv
// port c control and status of a three-port peripheral interface, with apb slave
// assumes apb master on pclk; peripheral pins synchronous to pclk
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppi_port_c_handshake_status
#(
  parameter bit CLEAR_PORT_B = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ppi_reset,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pc_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] la;
    logic [7:0] lb;
    logic [7:0] lc;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [7:0] pa_o;
    logic [7:0] pa_e;
    logic [7:0] pb_o;
    logic [7:0] pb_e;
    logic [7:0] pc_o;
    logic [7:0] pc_e;
  } top_state_t;
  top_state_t s_q;
  top_state_t s_d;

  ppi_pkg::apb_req_t req;
  logic setup;
  logic wr_c;
  logic wr_cw;
  logic wr_a;
  logic wr_b;
  logic rd_a;
  logic rd_b;
  logic bsr;
  logic [2:0] bsr_sel;
  logic bsr_val;
  logic long_reset;
  logic a_m1;
  logic a_m2;
  logic a_in;
  logic a_out;
  logic b_m1;
  logic b_in;
  logic [7:0] ctl_mask;
  logic [7:0] free_in;
  logic [7:0] status;
  logic a_ibf;
  logic a_obf_n;
  logic a_irq;
  logic a_iie;
  logic a_oie;
  logic b_ibf;
  logic b_obf_n;
  logic b_irq;
  logic b_iie;
  logic b_oie;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic hit(input ppi_pkg::apb_req_t r, input logic [7:0] off, input logic w);
    hit = r.psel && !r.penable && (r.pwrite == w) && (r.paddr == off);
  endfunction

  // transfers are acted on in the setup cycle; the answer follows one cycle later
  assign setup = psel && !penable;
  assign wr_cw = hit(req, ppi_pkg::OFF_CTRL, 1'b1) && pwdata[ppi_pkg::CW_FLAG];
  assign bsr = hit(req, ppi_pkg::OFF_CTRL, 1'b1) && !pwdata[ppi_pkg::CW_FLAG];
  assign bsr_sel = pwdata[ppi_pkg::BSR_SEL_HI:ppi_pkg::BSR_SEL_LO];
  assign bsr_val = pwdata[ppi_pkg::BSR_VAL];
  assign wr_a = hit(req, ppi_pkg::OFF_PORT_A, 1'b1);
  assign wr_b = hit(req, ppi_pkg::OFF_PORT_B, 1'b1);
  assign wr_c = hit(req, ppi_pkg::OFF_PORT_C, 1'b1);
  assign rd_a = hit(req, ppi_pkg::OFF_PORT_A, 1'b0);
  assign rd_b = hit(req, ppi_pkg::OFF_PORT_B, 1'b0);

  // mode decode from the current control word
  assign a_m2 = s_q.ctrl[ppi_pkg::CW_A_MODE_HI];
  assign a_m1 = !a_m2 && s_q.ctrl[ppi_pkg::CW_A_MODE_LO];
  assign a_in = a_m1 && s_q.ctrl[ppi_pkg::CW_A_DIR];
  assign a_out = a_m1 && !s_q.ctrl[ppi_pkg::CW_A_DIR];
  assign b_m1 = s_q.ctrl[ppi_pkg::CW_B_MODE];
  assign b_in = s_q.ctrl[ppi_pkg::CW_B_DIR];

  // port c bits used as handshake lines
  always_comb
  begin
    ctl_mask = 8'h00;
    if (a_in)
      ctl_mask[5:3] = 3'h7;
    if (a_out)
      ctl_mask = ctl_mask | 8'hc8;
    if (a_m2)
      ctl_mask[7:3] = 5'h1f;
    if (b_m1)
      ctl_mask[2:0] = 3'h7;
  end

  // free bits configured as inputs
  assign free_in = ~ctl_mask & {{4{s_q.ctrl[ppi_pkg::CW_CU_DIR]}},
                                {4{s_q.ctrl[ppi_pkg::CW_CL_DIR]}}};

  ////////////////////////////////////////////////////////////////////////////
  // handshake groups
  ppi_handshake u_grp_a (
    .pclk(pclk),
    .presetn(presetn),
    .strobe_in_n(pc_in[4]),
    .ack_in_n(pc_in[6]),
    .host_rd(rd_a),
    .host_wr(wr_a),
    .is_input(a_in || a_m2),
    .is_output(a_out || a_m2),
    .in_ie_set(bsr && bsr_sel == 3'h4 && bsr_val && (a_in || a_m2)),
    .in_ie_clr(bsr && bsr_sel == 3'h4 && !bsr_val && (a_in || a_m2)),
    .out_ie_set(bsr && bsr_sel == 3'h6 && bsr_val && (a_out || a_m2)),
    .out_ie_clr(bsr && bsr_sel == 3'h6 && !bsr_val && (a_out || a_m2)),
    .clr_all(wr_cw || long_reset),
    .input_buffer_full(a_ibf),
    .output_buffer_full_n(a_obf_n),
    .interrupt_request(a_irq),
    .input_irq_enable(a_iie),
    .output_irq_enable(a_oie)
  );

  ppi_handshake u_grp_b (
    .pclk(pclk),
    .presetn(presetn),
    .strobe_in_n(pc_in[2]),
    .ack_in_n(pc_in[2]),
    .host_rd(rd_b),
    .host_wr(wr_b),
    .is_input(b_m1 && b_in),
    .is_output(b_m1 && !b_in),
    .in_ie_set(bsr && bsr_sel == 3'h2 && bsr_val && b_m1 && b_in),
    .in_ie_clr(bsr && bsr_sel == 3'h2 && !bsr_val && b_m1 && b_in),
    .out_ie_set(bsr && bsr_sel == 3'h2 && bsr_val && b_m1 && !b_in),
    .out_ie_clr(bsr && bsr_sel == 3'h2 && !bsr_val && b_m1 && !b_in),
    .clr_all(wr_cw || long_reset),
    .input_buffer_full(b_ibf),
    .output_buffer_full_n(b_obf_n),
    .interrupt_request(b_irq),
    .input_irq_enable(b_iie),
    .output_irq_enable(b_oie)
  );

  ppi_reset_filter #(.MIN_CYC(ppi_pkg::RESET_MIN_CYC)) u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .ppi_reset(ppi_reset),
    .long_reset(long_reset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // port c status word
  always_comb
  begin
    status = (pc_in & free_in) | (s_q.lc & ~free_in & ~ctl_mask);
    if (a_in)
    begin
      status[5] = a_ibf;
      status[4] = a_iie;
      status[3] = a_irq;
    end
    if (a_out)
    begin
      status[7] = a_obf_n;
      status[6] = a_oie;
      status[3] = a_irq;
    end
    if (a_m2)
      status[7:3] = {a_obf_n, a_oie, a_ibf, a_iie, a_irq};
    if (b_m1)
      status[2:0] = {b_in ? b_iie : b_oie, b_in ? b_ibf : b_obf_n, b_irq};
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, latches and pin drive
  always_comb
  begin
    s_d = s_q;
    s_d.ready = setup;
    s_d.err = setup && !(paddr inside {ppi_pkg::OFF_PORT_A, ppi_pkg::OFF_PORT_B,
                                      ppi_pkg::OFF_PORT_C, ppi_pkg::OFF_CTRL});
    if (setup && !pwrite)
    begin
      unique case (paddr)
        ppi_pkg::OFF_PORT_A: s_d.rdata = {24'h0, s_q.ctrl[ppi_pkg::CW_A_DIR] ? pa_in : s_q.la};
        ppi_pkg::OFF_PORT_B: s_d.rdata = {24'h0, s_q.ctrl[ppi_pkg::CW_B_DIR] ? pb_in : s_q.lb};
        ppi_pkg::OFF_PORT_C: s_d.rdata = {24'h0, status};
        ppi_pkg::OFF_CTRL: s_d.rdata = {24'h0, s_q.ctrl};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (wr_a)
      s_d.la = pwdata[7:0];
    if (wr_b)
      s_d.lb = pwdata[7:0];
    if (wr_c)
      s_d.lc[2:0] = pwdata[2:0];
    if (bsr)
      s_d.lc[bsr_sel] = bsr_val;
    if (wr_cw)
    begin
      s_d.ctrl = pwdata[7:0];
      s_d.la = ppi_pkg::LATCH_RESET;
      s_d.lc = ppi_pkg::LATCH_RESET;
      if (CLEAR_PORT_B)
        s_d.lb = ppi_pkg::LATCH_RESET;
    end
    if (long_reset)
    begin
      s_d.ctrl = ppi_pkg::CTRL_RESET;
      s_d.la = ppi_pkg::LATCH_RESET;
      s_d.lb = ppi_pkg::LATCH_RESET;
      s_d.lc = ppi_pkg::LATCH_RESET;
    end
    // pin drive: free output bits, then handshake outputs
    s_d.pa_o = s_q.la;
    s_d.pa_e = (s_q.ctrl[ppi_pkg::CW_A_DIR] || a_m2) ? 8'h00 : 8'hff;
    s_d.pb_o = s_q.lb;
    s_d.pb_e = s_q.ctrl[ppi_pkg::CW_B_DIR] ? 8'h00 : 8'hff;
    s_d.pc_o = s_q.lc;
    s_d.pc_e = ~ctl_mask & ~free_in;
    if (a_in || a_m2)
    begin
      s_d.pc_o[5] = a_ibf;
      s_d.pc_e[5] = 1'b1;
    end
    if (a_out || a_m2)
    begin
      s_d.pc_o[7] = a_obf_n;
      s_d.pc_e[7] = 1'b1;
    end
    if (a_m1 || a_m2)
    begin
      s_d.pc_o[3] = a_irq;
      s_d.pc_e[3] = 1'b1;
    end
    if (b_m1)
    begin
      s_d.pc_o[1:0] = {b_in ? b_ibf : b_obf_n, b_irq};
      s_d.pc_e[1:0] = 2'h3;
    end
  end

  // async reset leaves every line undriven
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{ctrl: ppi_pkg::CTRL_RESET, default: '0};
    else
      s_q <= s_d;
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign pa_out = s_q.pa_o;
  assign pa_oe = s_q.pa_e;
  assign pb_out = s_q.pb_o;
  assign pb_oe = s_q.pb_e;
  assign pc_out = s_q.pc_o;
  assign pc_oe = s_q.pc_e;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_cw_clears_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cw && !long_reset) |=> (s_q.la == 8'h00 && s_q.lc == 8'h00))
    else $error("control write left a latch set");
  a_wr_c_upper_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_c && !bsr && !wr_cw && !long_reset) |=> $stable(s_q.lc[7:4]))
    else $error("port c write changed upper latch");
  a_bsr_low_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (bsr && bsr_sel < 3'h4 && !long_reset) |=> (s_q.lc[$past(bsr_sel)] == $past(bsr_val)))
    else $error("bit set missed low bit");
  a_long_reset_in: assert property (@(posedge pclk) disable iff (!presetn)
    long_reset |=> ##1 (pa_oe == 8'h00 && pb_oe == 8'h00 && pc_oe == 8'h00))
    else $error("long reset left a port driven");
  a_status_a_in: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ppi_pkg::OFF_PORT_C && a_in)
    |=> (prdata[5] == $past(a_ibf) && prdata[3] == $past(a_irq)))
    else $error("status read wrong for group a input");
  a_status_b: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ppi_pkg::OFF_PORT_C && b_m1)
    |=> (prdata[0] == $past(b_irq)))
    else $error("status read wrong for group b");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no ready after setup");
endmodule
`default_nettype wire

// File: rtl/ppi_reset_filter.sv
// reset pulse qualifier: counts the high reset and flags when it is long enough
// assumes ppi_reset is synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module ppi_reset_filter
#(
  parameter int MIN_CYC = ppi_pkg::RESET_MIN_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ppi_reset,
  output logic long_reset
);
  typedef struct packed {
    logic [7:0] cnt;
    logic fire;
  } rf_state_t;
  rf_state_t s_q;
  rf_state_t s_d;

  // shorter pulses count as glitches and are ignored
  always_comb
  begin
    s_d = s_q;
    s_d.fire = 1'b0;
    if (!ppi_reset)
      s_d.cnt = 8'h00;
    else if (s_q.cnt != 8'(MIN_CYC))
      s_d.cnt = s_q.cnt + 8'h01;
    s_d.fire = ppi_reset && (s_q.cnt == 8'(MIN_CYC));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign long_reset = s_q.fire;
endmodule
`default_nettype wire
